/* src/jms_map.svh */
// Jog mode sequencer: parameter addresses, field positions, resets, limits, timing.
// Assumes 16-bit parameter words addressed by their fieldbus parameter number.
`ifndef JMS_MAP_SVH
`define JMS_MAP_SVH

// Parameter addresses
`define JMS_ADDR_MODE_SELECT 16'h1B06
`define JMS_ADDR_ACTIVE_MODE 16'h1B08
`define JMS_ADDR_JOG_REQUEST 16'h1B12
`define JMS_ADDR_SLOW_SPEED 16'h2908
`define JMS_ADDR_FAST_SPEED 16'h290A
`define JMS_ADDR_STEP_DIST_HI 16'h290E
`define JMS_ADDR_STEP_DIST_LO 16'h290F
`define JMS_ADDR_WAIT_TIME 16'h2910

// Reset values
`define JMS_RST_MODE 16'h0000
`define JMS_RST_JOG_REQUEST 16'h0000
`define JMS_RST_SLOW_SPEED 16'h003C
`define JMS_RST_FAST_SPEED 16'h00B4
`define JMS_RST_STEP_DIST 32'h0000_0014
`define JMS_RST_WAIT_TIME 16'h01F4

// Mode codes and field positions
`define JMS_MODE_JOG 16'hFFFF
`define JMS_JOG_POS_BIT 0
`define JMS_JOG_NEG_BIT 1
`define JMS_JOG_FAST_BIT 2
`define JMS_JOG_REQ_MASK 16'h0007
`define JMS_STATUS_END_BIT 14

// Limits
`define JMS_SPEED_MIN 16'h0001
`define JMS_SPEED_MAX 16'h0BB8
`define JMS_WAIT_MIN 16'h0001
`define JMS_WAIT_MAX 16'h7FFF

// Timing
`define JMS_CLK_PERIOD_NS 100
`define JMS_MS_NS 1000000
`define JMS_MS_CYCLES (`JMS_MS_NS / `JMS_CLK_PERIOD_NS)

`endif

/* src/jms_pkg.sv */
// Jog mode sequencer types.
// Assumes nothing of its surroundings.
package jms_pkg;

  typedef enum logic [2:0] {
    JMS_IDLE = 3'b000,
    JMS_STEP = 3'b001,
    JMS_CONT = 3'b010,
    JMS_STOP = 3'b011
  } jms_state_t;

  typedef logic signed [15:0] jms_mode_t;

endpackage

/* src/jms_sequencer.sv */
// Jog mode sequencer: mode switching, active mode indication and jog motion.
// Assumes parameter accesses and motion feedback come from logic on clk_sys.
// What this block does
// - Active mode is reported read-only, signed 16 bits, same coding as mode select.
// - Request first moves the jog distance; held past wait time, runs continuously.
// - Motor position at the request is the start position; user units throughout.
// - Positive and negative requests together give no motor movement.
// - Zero jog distance starts continuous run at once, ignoring the wait time.
// - Request word: bit 0 positive, bit 1 negative, bit 2 fast; resets to zero.
// - Slow and fast speeds 1..3000, defaults 60 and 180, clamped to ramp maximum.
// - Jog distance is signed 32 bits, 0..2147483647, default 20.
// - Wait time 1..32767 ms, default 500, used only with nonzero distance.
// - Jog ends at standstill with no direction, or on halt or error.
// - Status bit 14 is set when the mode is complete and the motor stands still.
`timescale 1ns/100ps
`default_nettype none
`include "jms_map.svh"

module jms_sequencer #(
  parameter int unsigned MS_CYCLES = `JMS_MS_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Parameter access
  input wire logic [15:0] par_addr,
  input wire logic par_wr,
  input wire logic par_rd,
  input wire logic [15:0] par_wdata,
  output logic [15:0] par_rdata,
  output logic par_ack,
  // Drive feedback
  input wire logic signed [31:0] motor_pos,
  input wire logic motor_standstill,
  input wire logic halt,
  input wire logic fault,
  input wire logic [15:0] max_ramp_speed,
  // Motion commands
  output logic signed [31:0] step_target,
  output logic step_go,
  output logic run_enable,
  output logic run_negative,
  output logic [15:0] run_speed,
  // Status
  output logic [15:0] status_word
);
  import jms_pkg::*;

  jms_mode_t mode_select_q;
  jms_mode_t active_mode_q;
  logic [15:0] jog_request_q;
  logic [15:0] slow_speed_q;
  logic [15:0] fast_speed_q;
  logic [31:0] step_dist_q;
  logic [15:0] wait_time_q;
  logic [15:0] rdata_q;
  logic ack_q;
  jms_state_t state_q;
  jms_state_t state_d;
  logic signed [31:0] target_q;
  logic go_q;
  logic run_q;
  logic neg_q;
  logic [15:0] speed_q;
  logic timer_start;
  logic wait_expired;
  logic req_pos;
  logic req_neg;
  logic req_one;
  logic req_none;
  logic jog_mode;
  logic abort;
  logic [15:0] sel_speed;
  logic [15:0] lim_speed;

  // Register writes; out-of-range speeds and wait times are not taken
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_select_q <= jms_mode_t'(`JMS_RST_MODE);
      jog_request_q <= `JMS_RST_JOG_REQUEST;
      slow_speed_q <= `JMS_RST_SLOW_SPEED;
      fast_speed_q <= `JMS_RST_FAST_SPEED;
      step_dist_q <= `JMS_RST_STEP_DIST;
      wait_time_q <= `JMS_RST_WAIT_TIME;
    end else if (par_wr) begin
      unique case (par_addr)
        `JMS_ADDR_MODE_SELECT: mode_select_q <= jms_mode_t'(par_wdata);
        `JMS_ADDR_JOG_REQUEST: jog_request_q <= par_wdata & `JMS_JOG_REQ_MASK;
        `JMS_ADDR_SLOW_SPEED: begin
          if (par_wdata >= `JMS_SPEED_MIN && par_wdata <= `JMS_SPEED_MAX) begin
            slow_speed_q <= par_wdata;
          end
        end
        `JMS_ADDR_FAST_SPEED: begin
          if (par_wdata >= `JMS_SPEED_MIN && par_wdata <= `JMS_SPEED_MAX) begin
            fast_speed_q <= par_wdata;
          end
        end
        // Sign bit forced clear keeps the distance non-negative
        `JMS_ADDR_STEP_DIST_HI: step_dist_q[31:16] <= {1'b0, par_wdata[14:0]};
        `JMS_ADDR_STEP_DIST_LO: step_dist_q[15:0] <= par_wdata;
        `JMS_ADDR_WAIT_TIME: begin
          if (par_wdata >= `JMS_WAIT_MIN && par_wdata <= `JMS_WAIT_MAX) begin
            wait_time_q <= par_wdata;
          end
        end
        default: ;
      endcase
    end
  end

  // Registered read answer, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
    end else begin
      ack_q <= par_rd || par_wr;
      if (par_rd) begin
        unique case (par_addr)
          `JMS_ADDR_MODE_SELECT: rdata_q <= mode_select_q;
          `JMS_ADDR_ACTIVE_MODE: rdata_q <= active_mode_q;
          `JMS_ADDR_JOG_REQUEST: rdata_q <= jog_request_q;
          `JMS_ADDR_SLOW_SPEED: rdata_q <= slow_speed_q;
          `JMS_ADDR_FAST_SPEED: rdata_q <= fast_speed_q;
          `JMS_ADDR_STEP_DIST_HI: rdata_q <= step_dist_q[31:16];
          `JMS_ADDR_STEP_DIST_LO: rdata_q <= step_dist_q[15:0];
          `JMS_ADDR_WAIT_TIME: rdata_q <= wait_time_q;
          default: rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  // The selected mode becomes active only once the drive is idle and stopped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      active_mode_q <= jms_mode_t'(`JMS_RST_MODE);
    end else if (state_q == JMS_IDLE && motor_standstill) begin
      active_mode_q <= mode_select_q;
    end
  end

  assign jog_mode = (active_mode_q == jms_mode_t'(`JMS_MODE_JOG));
  assign req_pos = jog_request_q[`JMS_JOG_POS_BIT];
  assign req_neg = jog_request_q[`JMS_JOG_NEG_BIT];
  assign req_one = req_pos ^ req_neg;
  assign req_none = !req_one;
  assign abort = halt || fault || !jog_mode;

  // Speed choice limited to the ramp maximum
  assign sel_speed = jog_request_q[`JMS_JOG_FAST_BIT] ? fast_speed_q : slow_speed_q;
  assign lim_speed = (sel_speed > max_ramp_speed) ? max_ramp_speed : sel_speed;

  always_comb begin
    state_d = state_q;
    timer_start = 1'b0;
    unique case (state_q)
      JMS_IDLE: begin
        if (!abort && req_one) begin
          if (step_dist_q == 32'h0000_0000) begin
            state_d = JMS_CONT;
          end else begin
            state_d = JMS_STEP;
            timer_start = 1'b1;
          end
        end
      end
      JMS_STEP: begin
        if (abort || req_none) begin
          state_d = JMS_STOP;
        end else if (wait_expired) begin
          state_d = JMS_CONT;
        end
      end
      JMS_CONT: begin
        if (abort || req_none) begin
          state_d = JMS_STOP;
        end
      end
      JMS_STOP: begin
        if (motor_standstill) begin
          state_d = JMS_IDLE;
        end
      end
      default: state_d = JMS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= JMS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Step target taken from the motor position at the request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      target_q <= 32'sh0000_0000;
      go_q <= 1'b0;
    end else begin
      go_q <= timer_start;
      if (timer_start) begin
        target_q <= req_neg ? motor_pos - $signed(step_dist_q)
                            : motor_pos + $signed(step_dist_q);
      end
    end
  end

  // Continuous run command; dropped in the stop state so the drive ramps down
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      run_q <= 1'b0;
      neg_q <= 1'b0;
      speed_q <= 16'h0000;
    end else begin
      run_q <= (state_d == JMS_CONT);
      if (state_q == JMS_IDLE && state_d != JMS_IDLE) begin
        neg_q <= req_neg;
      end
      speed_q <= lim_speed;
    end
  end

  jms_wait_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_wait (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(timer_start),
    .wait_ms(wait_time_q),
    .expired(wait_expired)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_word <= 16'h0000;
    end else begin
      status_word <= 16'h0000;
      // Not reported in the cycle in which a new jog leaves idle
      status_word[`JMS_STATUS_END_BIT] <= (state_q == JMS_IDLE) && (state_d == JMS_IDLE)
                                          && motor_standstill;
    end
  end

  assign par_rdata = rdata_q;
  assign par_ack = ack_q;
  assign step_target = target_q;
  assign step_go = go_q;
  assign run_enable = run_q;
  assign run_negative = neg_q;
  assign run_speed = speed_q;

endmodule // jms_sequencer
`default_nettype wire

/* src/jms_wait_timer.sv */
// Millisecond wait timer for the jog sequencer.
// Assumes a single clock; start is a one-cycle pulse from the same domain.
`timescale 1ns/100ps
`default_nettype none
`include "jms_map.svh"

module jms_wait_timer #(
  parameter int unsigned MS_CYCLES = `JMS_MS_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic [15:0] wait_ms,
  // Result
  output logic expired
);
  import jms_pkg::*;

  logic [31:0] pre_q;
  logic tick;
  logic [15:0] ms_q;
  logic run_q;
  logic done_q;

  // One-cycle enable every millisecond, restarted with the timer
  assign tick = run_q && (pre_q == 32'(MS_CYCLES - 1));

  always_ff @(posedge clk_sys) begin
    if (rst || start || tick) begin
      pre_q <= 32'h0000_0000;
    end else if (run_q) begin
      pre_q <= pre_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ms_q <= 16'h0000;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else if (start) begin
      ms_q <= wait_ms;
      run_q <= 1'b1;
      done_q <= 1'b0;
    end else if (tick) begin
      ms_q <= ms_q - 16'h0001;
      if (ms_q == 16'h0001) begin
        run_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  assign expired = done_q;

endmodule // jms_wait_timer
`default_nettype wire

/* testbench/jms_master_model.sv */
// Fieldbus master model for the parameter port.
// Assumes strobes are taken at the rising edge of clk_sys.
`timescale 1ns/100ps
`default_nettype none
module jms_master_model (
  // Clock
  input wire logic clk_sys,
  // Parameter access
  output logic [15:0] par_addr,
  output logic par_wr,
  output logic par_rd,
  output logic [15:0] par_wdata,
  input wire logic [15:0] par_rdata,
  input wire logic par_ack
);
  initial begin
    par_addr = 16'h0000;
    par_wr = 1'b0;
    par_rd = 1'b0;
    par_wdata = 16'h0000;
  end
  // One-cycle strobe, then take the answer at the acknowledge edge
  task automatic access(input logic wr, input logic [15:0] a, d, output logic [15:0] q);
    @(posedge clk_sys);
    par_addr <= a;
    par_wdata <= d;
    par_wr <= wr;
    par_rd <= !wr;
    @(posedge clk_sys);
    par_wr <= 1'b0;
    par_rd <= 1'b0;
    // Released lines show no stale value
    par_addr <= ~a;
    par_wdata <= ~d;
    @(posedge clk_sys);
    q = par_ack ? par_rdata : 16'hBAD0;
  endtask
endmodule // jms_master_model
`default_nettype wire

/* testbench/jms_seq_props.sv */
// Port checker for the jog sequencer.
// Assumes it is bound onto jms_sequencer; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module jms_seq_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Watched ports
  input wire logic par_wr,
  input wire logic par_rd,
  input wire logic par_ack,
  input wire logic motor_standstill,
  input wire logic halt,
  input wire logic fault,
  input wire logic [15:0] max_ramp_speed,
  input wire logic step_go,
  input wire logic run_enable,
  input wire logic [15:0] run_speed,
  input wire logic [15:0] status_word
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ack_after_access_a: assert property ((par_wr || par_rd) |=> par_ack)
    else $error("no acknowledge after access");
  ack_has_cause_a: assert property (par_ack |-> $past(par_wr || par_rd))
    else $error("acknowledge without access");
  step_one_pulse_a: assert property (step_go |=> !step_go)
    else $error("step start longer than one cycle");
  step_not_running_a: assert property (step_go |-> !run_enable)
    else $error("step started during continuous run");
  speed_clamped_a: assert property (run_enable && $stable(max_ramp_speed) |->
    run_speed <= max_ramp_speed)
    else $error("run speed above ramp limit");
  halt_stops_a: assert property (halt |-> ##[1:2] !run_enable)
    else $error("run kept during halt");
  fault_stops_a: assert property (fault |-> ##[1:2] !run_enable)
    else $error("run kept during error");
  end_at_rest_a: assert property ($rose(status_word[14]) |->
    $past(motor_standstill) && !run_enable)
    else $error("mode end reported while moving");
  status_unused_a: assert property (status_word[13:0] == 14'h0000 && !status_word[15])
    else $error("unused status bits set");
endmodule // jms_seq_props
bind jms_sequencer jms_seq_props u_props (.clk_sys, .rst, .par_wr, .par_rd, .par_ack,
  .motor_standstill, .halt, .fault, .max_ramp_speed, .step_go, .run_enable, .run_speed,
  .status_word);
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the jog sequencer.
// Assumes the master model and a simple motor that stops when run drops.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_sys, rst, halt, fault, motor_standstill, par_wr, par_rd, par_ack;
  logic step_go, run_enable, run_negative;
  logic signed [31:0] motor_pos, step_target;
  logic [15:0] max_ramp_speed, par_addr, par_wdata, par_rdata, run_speed, status_word, q;
  int failures, n_tests;
  jms_sequencer #(.MS_CYCLES(4)) u_dut (.clk_sys, .rst, .par_addr, .par_wr, .par_rd,
    .par_wdata, .par_rdata, .par_ack, .motor_pos, .motor_standstill, .halt, .fault,
    .max_ramp_speed, .step_target, .step_go, .run_enable, .run_negative, .run_speed,
    .status_word);
  jms_master_model u_mst (.clk_sys, .par_addr, .par_wr, .par_rd, .par_wdata, .par_rdata,
    .par_ack);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) motor_standstill <= !run_enable;
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, d);
    u_mst.access(1'b1, a, d, q);
  endtask
  task automatic rc(input string what, input logic [15:0] a, exp);
    u_mst.access(1'b0, a, 16'h0000, q);
    check(what, q, exp);
  endtask
  task automatic wait_run(input logic v, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      if (run_enable === v) break;
    end
  endtask
  task automatic t_reset;
    rc("active", 16'h1B08, 16'h0000);
    rc("jog", 16'h1B12, 16'h0000);
    rc("slow", 16'h2908, 16'h003C);
    rc("fast", 16'h290A, 16'h00B4);
    rc("dist_hi", 16'h290E, 16'h0000);
    rc("dist_lo", 16'h290F, 16'h0014);
    rc("wait", 16'h2910, 16'h01F4);
    rc("unmapped", 16'h1B0A, 16'h0000);
  endtask
  task automatic t_limits;
    wr(16'h2908, 16'h0000);
    rc("slow_lo", 16'h2908, 16'h003C);
    wr(16'h2908, 16'h0BB9);
    rc("slow_hi", 16'h2908, 16'h003C);
    wr(16'h2908, 16'h0BB8);
    rc("slow_max", 16'h2908, 16'h0BB8);
    wr(16'h2908, 16'h003C);
    wr(16'h2910, 16'h0000);
    rc("wait_lo", 16'h2910, 16'h01F4);
    wr(16'h2910, 16'h8000);
    rc("wait_hi", 16'h2910, 16'h01F4);
    wr(16'h2910, 16'h0001);
    rc("wait_min", 16'h2910, 16'h0001);
    wr(16'h290E, 16'hFFFF);
    rc("dist_sign", 16'h290E, 16'h7FFF);
    wr(16'h290E, 16'h0000);
    wr(16'h1B08, 16'h0005);
    rc("active_ro", 16'h1B08, 16'h0000);
    wr(16'h1B12, 16'hFFFF);
    rc("jog_mask", 16'h1B12, 16'h0007);
    wr(16'h1B12, 16'h0000);
  endtask
  task automatic t_mode;
    wr(16'h1B06, 16'hFFFF);
    repeat (2) @(posedge clk_sys);
    rc("active_jog", 16'h1B08, 16'hFFFF);
  endtask
  task automatic t_step;
    motor_pos <= 32'sh0000_0064;
    wr(16'h1B12, 16'h0001);
    repeat (5) begin
      @(posedge clk_sys);
      if (step_go === 1'b1) break;
    end
    check("step_go", step_go, 1'b1);
    check("target", step_target, 32'h0000_0078);
    // A 1 ms wait is four cycles here, so no run yet
    repeat (2) @(posedge clk_sys);
    check("early", run_enable, 1'b0);
    wait_run(1'b1, 20);
    @(posedge clk_sys);
    check("run", run_enable, 1'b1);
    check("dir", run_negative, 1'b0);
    check("speed", run_speed, 16'h003C);
    wr(16'h1B12, 16'h0000);
    wait_run(1'b0, 4);
    check("stop", run_enable, 1'b0);
    repeat (6) @(posedge clk_sys);
    check("end", status_word[14], 1'b1);
  endtask
  task automatic t_cont;
    max_ramp_speed <= 16'h0064;
    wr(16'h290F, 16'h0000);
    wr(16'h1B12, 16'h0006);
    wait_run(1'b1, 3);
    check("direct_run", run_enable, 1'b1);
    repeat (2) @(posedge clk_sys);
    check("neg", run_negative, 1'b1);
    check("clamp", run_speed, 16'h0064);
    halt <= 1'b1;
    wait_run(1'b0, 3);
    check("halt", run_enable, 1'b0);
    wr(16'h1B12, 16'h0000);
    halt <= 1'b0;
    wr(16'h1B12, 16'h0001);
    wait_run(1'b1, 4);
    fault <= 1'b1;
    wait_run(1'b0, 3);
    check("fault", run_enable, 1'b0);
    wr(16'h1B12, 16'h0000);
    fault <= 1'b0;
    max_ramp_speed <= 16'h0BB8;
  endtask
  task automatic t_both;
    logic moved;
    moved = 1'b0;
    wr(16'h290F, 16'h0014);
    wr(16'h1B12, 16'h0003);
    repeat (20) begin
      @(posedge clk_sys);
      moved |= step_go | run_enable;
    end
    check("both", moved, 1'b0);
    // Negative step, withdrawn before the wait time runs out
    wr(16'h1B12, 16'h0002);
    @(posedge clk_sys);
    check("neg_go", step_go, 1'b1);
    check("neg_target", step_target, 32'h0000_0050);
    wr(16'h1B12, 16'h0000);
    repeat (10) begin
      @(posedge clk_sys);
      moved |= run_enable;
    end
    check("short", moved, 1'b0);
    wr(16'h1B06, 16'h0000);
    repeat (2) @(posedge clk_sys);
    rc("active_off", 16'h1B08, 16'h0000);
  endtask
  task automatic finish_test;
    if (failures == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    halt = 1'b0;
    fault = 1'b0;
    motor_pos = 32'sh0000_0000;
    max_ramp_speed = 16'h0BB8;
    failures = 0;
    n_tests = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_limits;
    t_mode;
    t_step;
    t_cont;
    t_both;
    finish_test;
  end
  initial begin
    #2000000;
    failures++;
    finish_test;
  end
endmodule // testbench
`default_nettype wire
